// *** sbsc_top.v ***
/*
 * SRAM burst address generator, read mode select and sleep control,
 * reached as a classic Wishbone slave. A sleep request register models the
 * sleep pin; the memory is a small window at SBSC_ADR_MEM.
 * Assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/100ps
`default_nettype none
`include "sbsc_consts.vh"
module sbsc_top #(
    parameter MEM_AW = 8,
    parameter RECOVERY_CYC = `SBSC_RECOVERY_CYC
) (
    input wire core_clk_i,       // Clock
    input wire rst_i,            // Async reset, high
    input wire wb_cyc_i,         // Bus cycle
    input wire wb_stb_i,         // Strobe
    input wire wb_we_i,          // Write enable
    input wire [31:0] wb_adr_i,  // Byte address
    input wire [3:0] wb_sel_i,   // Byte selects
    input wire [31:0] wb_dat_i,  // Write data
    output reg [31:0] wb_dat_o,  // Read data
    output reg wb_ack_o,         // Acknowledge
    output reg wb_err_o,         // Refused access
    output reg [1:0] burst_a_o,  // Burst low address bits
    output reg asleep_o,         // Device in sleep
    output reg data_oe_n_o       // Data pins driven when low
);
    localparam ST_RUN = 2'h0;
    localparam ST_ENTER = 2'h1;
    localparam ST_SLEEP = 2'h2;
    localparam ST_RECOV = 2'h3;
    localparam [2:0] RG_SLEEP = 3'h0;
    localparam [2:0] RG_CFG = 3'h1;
    localparam [2:0] RG_STAT = 3'h2;
    localparam [2:0] RG_MEM = 3'h3;
    localparam [2:0] RG_NONE = 3'h4;
    localparam [31:0] MEM_BASE = `SBSC_ADR_MEM;
    // The request cycle seen in RUN counts as the first entry cycle
    localparam integer ENTER_LAST = `SBSC_SLEEP_ENTRY_CYC - 2;

    reg [1:0] st_q;
    reg [1:0] st_d;
    reg sleep_request_q;
    reg [2:0] cfg_q;
    reg [1:0] enter_cnt_q;
    reg [15:0] rec_cnt_q;
    reg [1:0] start_q;
    reg [1:0] beat_q;
    reg pend_q;
    reg [1:0] pipe_q;
    wire req;
    wire hit_mem;
    wire [2:0] region;
    wire [31:0] mem_rdata;
    reg mem_we;

    // Beat address from start and beat index
    function [1:0] sbsc_next;
        input [1:0] start;
        input [1:0] beat;
        input order;
        begin
            if (order) begin
                sbsc_next = start ^ beat; // RULE1
            end else begin
                sbsc_next = start + beat; // RULE1
            end
        end
    endfunction

    // Register bus region of a byte address
    function [2:0] sbsc_region;
        input [31:0] adr;
        begin
            if (adr == `SBSC_ADR_SLEEP) begin
                sbsc_region = RG_SLEEP;
            end else if (adr == `SBSC_ADR_CFG) begin
                sbsc_region = RG_CFG;
            end else if (adr == `SBSC_ADR_STAT) begin
                sbsc_region = RG_STAT;
            end else if (adr[31:10] == MEM_BASE[31:10]) begin
                sbsc_region = RG_MEM;
            end else begin
                sbsc_region = RG_NONE;
            end
        end
    endfunction

    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign region = sbsc_region(wb_adr_i);
    assign hit_mem = (region == RG_MEM);

    always @* begin
        st_d = st_q;
        case (st_q)
            ST_RUN: begin
                if (sleep_request_q) begin
                    st_d = ST_ENTER;
                end
            end
            ST_ENTER: begin
                if (!sleep_request_q) begin
                    st_d = ST_RUN;
                end else if ({30'h0, enter_cnt_q} == ENTER_LAST) begin
                    st_d = ST_SLEEP; // RULE3
                end
            end
            ST_SLEEP: begin
                if (!sleep_request_q) begin
                    st_d = ST_RECOV; // RULE6
                end
            end
            default: begin
                if (sleep_request_q) begin
                    st_d = ST_ENTER;
                end else if ({16'h0, rec_cnt_q} == RECOVERY_CYC - 1) begin
                    st_d = ST_RUN; // RULE7
                end
            end
        endcase
    end

    always @* begin
        mem_we = 1'b0;
        // Request still stands in the answer cycle: write only once
        if (req && !pend_q && wb_we_i && hit_mem &&
            st_q == ST_RUN) begin // RULE4
            mem_we = 1'b1; // RULE9
        end
    end

    sbsc_mem #(
        .AW(MEM_AW),
        .DW(32)
    ) u_mem (
        .clk_i(core_clk_i),
        .we_i(mem_we),
        .addr_i({start_q, wb_adr_i[MEM_AW+1:4]} ^
                {sbsc_next(start_q, beat_q, cfg_q[`SBSC_CFG_ORDER]),
                 {(MEM_AW-2){1'b0}}}),
        .wdata_i(wb_dat_i),
        .rdata_o(mem_rdata)
    );

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= ST_RUN;
            sleep_request_q <= 1'b0; // RULE11
            cfg_q <= 3'h6; // RULE11
            enter_cnt_q <= 2'h0;
            rec_cnt_q <= 16'h0000;
            start_q <= 2'h0;
            beat_q <= 2'h0;
            pend_q <= 1'b0;
            pipe_q <= 2'h0;
            wb_dat_o <= 32'h0000_0000;
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            burst_a_o <= 2'h0;
            asleep_o <= 1'b0;
            data_oe_n_o <= 1'b1;
        end else begin
            st_q <= st_d;
            enter_cnt_q <= (st_q == ST_ENTER) ? enter_cnt_q + 2'h1 : 2'h0;
            rec_cnt_q <= (st_q == ST_RECOV) ? rec_cnt_q + 16'h0001 : 16'h0000;
            asleep_o <= (st_d == ST_SLEEP); // RULE5
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            pend_q <= 1'b0;
            pipe_q <= {pipe_q[0], 1'b0};
            // Follows the next state so it never lags asleep_o
            if (st_d == ST_SLEEP) begin
                data_oe_n_o <= 1'b1; // RULE5
            end else if (pipe_q[cfg_q[`SBSC_CFG_FT] ? 1 : 0]) begin
                data_oe_n_o <= 1'b0; // RULE12
            end else begin
                data_oe_n_o <= 1'b1;
            end
            if (pend_q) begin
                wb_ack_o <= 1'b1;
                wb_dat_o <= mem_rdata;
                // Only reads drive the data pins
                pipe_q[0] <= ~wb_we_i;
            end else if (req) begin
                if (region == RG_SLEEP) begin
                    wb_ack_o <= 1'b1;
                    wb_dat_o <= {31'h0, sleep_request_q};
                    if (wb_we_i && wb_sel_i[0]) begin
                        sleep_request_q <= wb_dat_i[0]; // RULE6
                    end
                end else if (st_q == ST_SLEEP || st_q == ST_ENTER) begin
                    wb_err_o <= 1'b1; // RULE5
                end else if (region == RG_CFG) begin
                    wb_ack_o <= 1'b1;
                    wb_dat_o <= {29'h0, cfg_q};
                    if (wb_we_i && wb_sel_i[0] && st_q == ST_RUN) begin
                        cfg_q <= wb_dat_i[2:0]; // RULE2
                        start_q <= 2'h0;
                        beat_q <= 2'h0;
                    end
                end else if (region == RG_STAT) begin
                    wb_ack_o <= 1'b1;
                    wb_dat_o <= {26'h0, burst_a_o, beat_q, st_q};
                end else if (hit_mem) begin
                    if (wb_we_i && st_q == ST_RECOV) begin
                        wb_err_o <= 1'b1; // RULE9
                    end else begin
                        pend_q <= 1'b1;
                        if (beat_q == 2'h0) begin
                            start_q <= wb_adr_i[3:2];
                        end
                        burst_a_o <= sbsc_next(
                            (beat_q == 2'h0) ? wb_adr_i[3:2] : start_q,
                            beat_q, cfg_q[`SBSC_CFG_ORDER]); // RULE1
                        beat_q <= beat_q + 2'h1; // RULE1
                    end
                end else begin
                    wb_err_o <= 1'b1;
                end
            end
            // Refused accesses leave memory and burst position as they were
        end
    end
endmodule
`default_nettype wire

// *** sbsc_consts.vh ***
/*
 * Constants for the burst and sleep controller of a synchronous SRAM.
 * Assumes it is included by bare name from the design files.
 */
// Operation
// (RULE1) Four-beat burst makes low address bits, linear or interleaved, wraps on fifth.
// (RULE2) Burst order select is static: low linear, high interleaved.
// (RULE3) Sleep request high puts the device asleep two clocks later.
// (RULE4) Asleep, all state and stored contents stay unchanged.
// (RULE5) Asleep, device acts deselected, ignores inputs, outputs high impedance.
// (RULE6) Sleep request is active high and sleep lasts while it stays high.
// (RULE7) After sleep request falls, normal operation resumes after recovery time.
// (RULE8) Controller raises sleep request only with no operation pending.
// (RULE9) During recovery the controller issues only deselect or read.
// (RULE10) Controller holds sleep request low in normal operation, or leaves it open.
// (RULE11) Unconnected drive and flow-through selects read high; sleep request low.
// (RULE12) Flow-through select chooses flow-through or pipelined read mode.
`ifndef SBSC_CONSTS_VH
`define SBSC_CONSTS_VH
`define SBSC_CLK_MHZ 50
`define SBSC_SLEEP_ENTRY_CYC 2
`define SBSC_RECOVERY_NS 40
`define SBSC_RECOVERY_CYC ((`SBSC_RECOVERY_NS * `SBSC_CLK_MHZ + 999) / 1000)
`define SBSC_ADDR_W 16
`define SBSC_DATA_W 32
`define SBSC_ADR_SLEEP 32'h0000_0000
`define SBSC_ADR_CFG 32'h0000_0004
`define SBSC_ADR_STAT 32'h0000_0008
`define SBSC_ADR_MEM 32'h0000_0400
`define SBSC_CFG_RST 32'h0000_0006
`define SBSC_CFG_ORDER 0
`define SBSC_CFG_FT 1
`define SBSC_CFG_DRIVE 2
`endif

// *** sbsc_mem.v ***
/*
 * Small synchronous storage array with registered read data.
 * Assumes one clock; write and read may both occur each cycle.
 */
`timescale 1ns/100ps
`default_nettype none
module sbsc_mem #(
    parameter AW = 8,
    parameter DW = 32
) (
    input wire clk_i,            // Clock
    input wire we_i,             // Write strobe
    input wire [AW-1:0] addr_i,  // Word address
    input wire [DW-1:0] wdata_i, // Write data
    output reg [DW-1:0] rdata_o  // Registered read data
);
    reg [DW-1:0] mem_q [0:(1<<AW)-1];

    always @(posedge clk_i) begin
        if (we_i) begin
            mem_q[addr_i] <= wdata_i;
        end
        rdata_o <= mem_q[addr_i];
    end
endmodule
`default_nettype wire

// *** sbsc_top_sva.sv ***
/* Port checker for sbsc_top.
   Assumes it is bound to sbsc_top and one clock domain. */
`timescale 1ns/100ps
`default_nettype none
module sbsc_top_sva #(parameter MEM_AW = 8, parameter RECOVERY_CYC = 2) (
    input wire logic core_clk_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_we_i, // Write
    input wire logic [31:0] wb_adr_i, // Address
    input wire logic [31:0] wb_dat_i, // Write data
    input wire logic wb_ack_o, // Acknowledge
    input wire logic wb_err_o, // Refused
    input wire logic [1:0] burst_a_o, // Burst bits
    input wire logic asleep_o, // Asleep
    input wire logic data_oe_n_o // Data drive, low
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    wire logic mem = wb_adr_i[31:10] == 22'h1;
    wire logic reg0 = wb_adr_i == 32'h0;
    chk_sleep_entry: assert property (
        wb_ack_o && wb_we_i && reg0 && wb_dat_i[0] |-> ##[1:2] asleep_o)
        else $error("sleep not entered");
    chk_out_hiz: assert property (asleep_o |-> data_oe_n_o)
        else $error("data driven in sleep");
    chk_sleep_refuse: assert property (
        asleep_o && $rose(wb_stb_i) && !reg0 |=> wb_err_o && !wb_ack_o)
        else $error("access not refused in sleep");
    chk_sleep_reg: assert property ($rose(wb_stb_i) && reg0 |=> wb_ack_o)
        else $error("sleep request not accepted");
    chk_mem_ack: assert property (
        $rose(wb_stb_i) && mem && !wb_we_i && !asleep_o
        |-> ##1 !wb_ack_o ##1 wb_ack_o) else $error("read ack late");
    chk_read_drive: assert property (
        $rose(wb_stb_i) && mem && !wb_we_i && !asleep_o
        |-> ##[3:4] !data_oe_n_o) else $error("read data not driven");
    chk_state_hold: assert property (asleep_o |=> $stable(burst_a_o))
        else $error("burst state moved in sleep");
    chk_wake: assert property (
        wb_ack_o && wb_we_i && reg0 && !wb_dat_i[0] && asleep_o
        |-> ##[1:4] !asleep_o) else $error("no wake");
endmodule
bind sbsc_top sbsc_top_sva #(.MEM_AW(MEM_AW), .RECOVERY_CYC(RECOVERY_CYC)) chk (
    .core_clk_i, .rst_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
    .wb_ack_o, .wb_err_o, .burst_a_o, .asleep_o, .data_oe_n_o);
`default_nettype wire

// *** sbsc_ctl_model.sv ***
/* Memory controller model: a classic Wishbone master.
   Assumes the caller issues one transfer at a time. */
`timescale 1ns/100ps
`default_nettype none
module sbsc_ctl_model (
    input wire logic clk_i, // Clock
    input wire logic ack_i, // Acknowledge
    input wire logic err_i, // Refused
    output logic cyc_o, // Cycle
    output logic stb_o, // Strobe
    output logic we_o, // Write
    output logic [31:0] adr_o, // Address
    output logic [31:0] dat_o, // Write data
    output logic hung_o // No answer came
);
    initial {cyc_o, stb_o, we_o, adr_o, dat_o, hung_o} = '0;
    task automatic xfer(input logic w, input logic [31:0] a, d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc_o, stb_o, we_o, adr_o, dat_o} <= {2'b11, w, a, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (!ack_i && !err_i && n < 20);
        // Stale write data inverted so it cannot pass for fresh
        {cyc_o, stb_o, dat_o, hung_o} <= {2'b00, ~d, ~(ack_i | err_i)};
    endtask
endmodule
`default_nettype wire

// *** sram_burst_and_sleep_control_bench.sv ***
/* Self-checking bench for sbsc_top driven through the controller model.
   Assumes the hand-over bus timing and a two-cycle recovery. */
`timescale 1ns/100ps
`default_nettype none
module sram_burst_and_sleep_control_bench;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, stb, we, ack, err, asleep, oe_n, hung;
    logic [31:0] adr, wdat, rdat;
    logic [1:0] ba, s;
    logic [33:0] note;
    logic [33:0] exp_q[$]; // Data-valid flag, err, data
    logic [31:0] d[4];
    int num_errors = 0;
    int checks = 0;
    initial forever #10 core_clk_i = ~core_clk_i;
    sbsc_top #(.MEM_AW(8), .RECOVERY_CYC(2)) uut (.core_clk_i, .rst_i,
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .wb_err_o(err), .burst_a_o(ba), .asleep_o(asleep), .data_oe_n_o(oe_n));
    sbsc_ctl_model ctl (.clk_i(core_clk_i), .ack_i(ack), .err_i(err),
        .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .dat_o(wdat),
        .hung_o(hung));
    task automatic check(input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        if (num_errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic op(input logic w, input logic [31:0] a, dv,
                      input logic [33:0] n);
        exp_q.push_back(n);
        ctl.xfer(w, a, dv);
    endtask
    always @(posedge core_clk_i) begin
        if (ack === 1'b1 || err === 1'b1) begin
            // Unexpected answer compares against unknown data and fails
            note = exp_q.size() ? exp_q.pop_front() : {2'b10, 32'bx};
            check({31'b0, err}, {31'b0, note[32]});
            if (note[33]) check(rdat, note[31:0]);
        end
    end
    always @(posedge hung) begin
        num_errors++;
        test_done();
    end
    initial begin
        void'($urandom(32'hae01));
        repeat (4) @(posedge core_clk_i);
        rst_i <= 1'b0;
        op(0, 32'h4, 0, {2'b10, 32'h6});
        op(0, 32'hc, 0, {2'b01, 32'h0});
        for (int m = 0; m < 4; m++) begin
            op(1, 32'h4, 32'h4 | m, 34'h0);
            s = $urandom;
            for (int k = 0; k < 8; k++) begin
                if (k < 4) d[k] = $urandom;
                op(k < 4, 32'h400 | {s, 2'b0}, d[k % 4],
                   {k > 3, 1'b0, d[k % 4]});
                check({30'b0, ba},
                      {30'b0, m[0] ? s ^ k[1:0] : s + k[1:0]});
            end
        end
        op(0, 32'h8, 0, {2'b10, 26'h0, s ^ 2'h3, 4'h0});
        op(1, 32'h0, 32'h1, 34'h0);
        repeat (3) @(posedge core_clk_i);
        check({30'b0, asleep, oe_n}, 32'h3);
        op(0, 32'h404, 0, {2'b01, 32'h0});
        check({30'b0, ba}, {30'b0, s ^ 2'h3});
        op(0, 32'h0, 0, {2'b10, 32'h1});
        op(1, 32'h0, 32'h0, 34'h0);
        op(0, 32'h400 | {s, 2'b0}, 0, {2'b10, d[0]});
        check({31'b0, asleep}, 32'h0);
        check({30'b0, ba}, {30'b0, s});
        op(0, 32'h8, 0, {2'b10, 26'h0, s, 4'h4});
        // Let the answer checker take the last answer first
        repeat (2) @(posedge core_clk_i);
        test_done();
    end
endmodule
`default_nettype wire
